// ### verilog/see_pkg.sv
// shared constants and types of the serial memory slave
package see_pkg;
	localparam int SEE_CLK_NS = 4;
	localparam int SEE_PROG_TIME_US = 10000;
	localparam int SEE_PROG2_TIME_US = 20000;
	localparam int SEE_PROG_CYC = SEE_PROG_TIME_US * 1000 / SEE_CLK_NS;
	localparam int SEE_PROG2_CYC = SEE_PROG2_TIME_US * 1000 / SEE_CLK_NS;
	localparam logic [6:0] SEE_DEV_ID_DFLT = 7'h3B; // arbitrary value
	localparam logic [7:0] SEE_ERASED_BYTE = 8'hFF;
	localparam logic [3:0] SEE_BITS_BYTE = 4'h8;
	localparam logic [3:0] SEE_BITS_ACK = 4'h9;
	localparam int SEE_FIFO_DEPTH = 8;
	localparam int SEE_MEM_BYTES = 256;

	typedef enum logic [2:0] {
		SEE_IDLE,
		SEE_SEL,
		SEE_ADDR,
		SEE_WDATA,
		SEE_ACK,
		SEE_RDATA,
		SEE_RACK,
		SEE_PROG
	} see_state_e;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} see_wr_s;

	function automatic logic [7:0] see_next_addr(input logic [7:0] a, input logic page);
		see_next_addr = page ? {a[7:3], 3'(a[2:0] + 3'h1)} : 8'(a + 8'h01);
	endfunction : see_next_addr
endpackage : see_pkg

// ### verilog/see_slave.sv
// two-wire serial memory slave with write buffer
// What this block does
// - start is data falling while clock high; idle until one is seen
// - stop is data rising while clock high; ends the exchange
// - stop after a read command returns the device to standby
// - transmitter releases data after eight bits; receiver pulls low on ninth
// - received bits are sampled on serial clock rising edges
// - select byte: seven identifier bits then direction bit, msb first
// - acknowledge select only when identifier matches the fixed code
// - write select followed by byte address, loaded and acknowledged
// - mode high selects multibyte write, low selects page write
// - single byte write works in either mode
// - multibyte write starts anywhere, one to eight bytes, each acknowledged
// - multibyte program time 10 ms, 20 ms when two rows are touched
// - page write wraps only the low three address bits
// - stop after write starts programming; bus ignored until done
// - no acknowledge to select while programming; polling allowed
// - reads ignore mode; address counter increments per byte read
// - current address read outputs counter byte then increments
// - random read: dummy write loads address, repeated start, read
// - unwritten memory reads all ones
// - stop after write commits the latched bytes
// - sequential read continues while acknowledged; counter wraps to zero
// - master not acknowledging ends the read, device goes standby
`timescale 1ns/1ns
`default_nettype none

module see_fifo #(
	parameter int W = 16,
	parameter int D = 8
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	localparam logic [AW:0] FULL = (AW + 1)'(D);
	localparam logic [AW-1:0] LAST = AW'(D - 1);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} see_fifo_s;

	see_fifo_s s_ff;
	see_fifo_s nxt_s;
	logic push;
	logic pop;

	assign in_ready = s_ff.cnt != FULL;
	assign out_valid = s_ff.cnt != '0;
	assign out_data = s_ff.mem[s_ff.rp];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_comb begin
		nxt_s = s_ff;
		if (push) begin
			nxt_s.mem[s_ff.wp] = in_data;
			nxt_s.wp = (s_ff.wp == LAST) ? '0 : AW'(s_ff.wp + 1'b1);
		end
		if (pop) begin
			nxt_s.rp = (s_ff.rp == LAST) ? '0 : AW'(s_ff.rp + 1'b1);
		end
		nxt_s.cnt = (AW + 1)'(s_ff.cnt + {AW'(0), push} - {AW'(0), pop});
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end
endmodule : see_fifo

module see_slave
	import see_pkg::*;
#(
	parameter int PROG_CYC = see_pkg::SEE_PROG_CYC,
	parameter int PROG2_CYC = see_pkg::SEE_PROG2_CYC,
	parameter logic [6:0] DEV_ID = see_pkg::SEE_DEV_ID_DFLT
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic mode_in,
	output logic busy
);
	import see_pkg::*;

	typedef struct packed {
		logic [2:0] scl_s;
		logic [2:0] sda_s;
		logic [1:0] mode_s;
		see_state_e st;
		see_state_e after;
		logic [3:0] bits;
		logic [7:0] sh;
		logic drv;
		logic mack;
		logic [7:0] addr;
		logic [7:0] first;
		logic wr_any;
		logic multi;
		logic span;
		logic [31:0] tmr;
		logic [SEE_MEM_BYTES-1:0][7:0] mem;
	} see_slave_s;

	see_slave_s s_ff;
	see_slave_s nxt_s;
	logic scl;
	logic sda;
	logic rise;
	logic fall;
	logic start;
	logic stop;
	logic push;
	logic push_rdy;
	logic pop_v;
	logic pop_rdy;
	see_wr_s push_d;
	see_wr_s pop_d;

	// stage [0] feeds stage [1] only; [2] is the previous sampled level
	assign scl = s_ff.scl_s[1];
	assign sda = s_ff.sda_s[1];
	assign rise = scl & ~s_ff.scl_s[2];
	assign fall = ~scl & s_ff.scl_s[2];
	assign start = scl & s_ff.scl_s[2] & s_ff.sda_s[2] & ~sda;
	assign stop = scl & s_ff.scl_s[2] & ~s_ff.sda_s[2] & sda;
	assign pop_rdy = s_ff.st == SEE_PROG;
	assign push_d = '{addr: s_ff.addr, data: s_ff.sh};
	assign sda_out = 1'b0;
	assign sda_oe_n = ~s_ff.drv;
	assign busy = s_ff.st == SEE_PROG;

	see_fifo #(
		.W($bits(see_wr_s)),
		.D(SEE_FIFO_DEPTH)
	) u_buf (
		.ref_clk(ref_clk),
		.reset(reset),
		.in_valid(push),
		.in_ready(push_rdy),
		.in_data(push_d),
		.out_valid(pop_v),
		.out_ready(pop_rdy),
		.out_data(pop_d)
	);

	always_comb begin
		nxt_s = s_ff;
		push = 1'b0;
		nxt_s.scl_s = {s_ff.scl_s[1:0], scl_in};
		nxt_s.sda_s = {s_ff.sda_s[1:0], sda_in};
		nxt_s.mode_s = {s_ff.mode_s[0], mode_in};
		if (s_ff.st == SEE_PROG) begin
			// bus ignored; commit buffered bytes then wait out the cycle
			if (pop_v) begin
				nxt_s.mem[pop_d.addr] = pop_d.data;
			end
			if (s_ff.tmr != '0) begin
				nxt_s.tmr = s_ff.tmr - 32'h1;
			end else if (!pop_v) begin
				nxt_s.st = SEE_IDLE;
			end
		end else if (start) begin
			nxt_s.st = SEE_SEL;
			nxt_s.bits = '0;
			nxt_s.drv = 1'b0;
			nxt_s.wr_any = 1'b0;
		end else if (stop) begin
			nxt_s.drv = 1'b0;
			nxt_s.bits = '0;
			if (s_ff.wr_any) begin
				nxt_s.st = SEE_PROG;
				nxt_s.wr_any = 1'b0;
				nxt_s.tmr = s_ff.span ? 32'(PROG2_CYC - 1) : 32'(PROG_CYC - 1);
			end else begin
				nxt_s.st = SEE_IDLE;
			end
		end else if (s_ff.st != SEE_IDLE && rise) begin
			if (s_ff.st == SEE_RACK) begin
				nxt_s.mack = ~sda;
			end else if (s_ff.bits < SEE_BITS_BYTE) begin
				if (s_ff.st != SEE_RDATA) begin
					nxt_s.sh = {s_ff.sh[6:0], sda};
				end
				nxt_s.bits = 4'(s_ff.bits + 4'h1);
			end
		end else if (s_ff.st != SEE_IDLE && fall) begin
			unique case (s_ff.st)
				SEE_SEL: begin
					if (s_ff.bits == SEE_BITS_BYTE) begin
						nxt_s.bits = SEE_BITS_ACK;
						if (s_ff.sh[7:1] == DEV_ID) begin
							nxt_s.drv = 1'b1;
							nxt_s.st = SEE_ACK;
							nxt_s.after = s_ff.sh[0] ? SEE_RDATA : SEE_ADDR;
						end else begin
							nxt_s.st = SEE_IDLE;
						end
					end
				end
				SEE_ADDR: begin
					if (s_ff.bits == SEE_BITS_BYTE) begin
						nxt_s.bits = SEE_BITS_ACK;
						nxt_s.addr = s_ff.sh;
						nxt_s.drv = 1'b1;
						nxt_s.st = SEE_ACK;
						nxt_s.after = SEE_WDATA;
					end
				end
				SEE_WDATA: begin
					if (s_ff.bits == SEE_BITS_BYTE) begin
						nxt_s.bits = SEE_BITS_ACK;
						if (push_rdy) begin
							push = 1'b1;
							nxt_s.drv = 1'b1;
							nxt_s.st = SEE_ACK;
							nxt_s.after = SEE_WDATA;
							nxt_s.wr_any = 1'b1;
							nxt_s.addr = see_next_addr(s_ff.addr, ~s_ff.mode_s[1]);
							if (!s_ff.wr_any) begin
								nxt_s.first = s_ff.addr;
								nxt_s.multi = s_ff.mode_s[1];
								nxt_s.span = 1'b0;
							end else if (s_ff.multi && s_ff.addr[7:2] != s_ff.first[7:2]) begin
								nxt_s.span = 1'b1;
							end
						end else begin
							nxt_s.st = SEE_IDLE;
						end
					end
				end
				SEE_ACK: begin
					nxt_s.drv = 1'b0;
					nxt_s.bits = '0;
					nxt_s.st = s_ff.after;
					if (s_ff.after == SEE_RDATA) begin
						nxt_s.sh = s_ff.mem[s_ff.addr];
						nxt_s.drv = ~s_ff.mem[s_ff.addr][7];
						nxt_s.addr = see_next_addr(s_ff.addr, 1'b0);
					end
				end
				SEE_RDATA: begin
					if (s_ff.bits == SEE_BITS_BYTE) begin
						nxt_s.drv = 1'b0;
						nxt_s.st = SEE_RACK;
					end else begin
						nxt_s.sh = {s_ff.sh[6:0], 1'b0};
						nxt_s.drv = ~s_ff.sh[6];
					end
				end
				SEE_RACK: begin
					nxt_s.bits = '0;
					if (s_ff.mack) begin
						nxt_s.st = SEE_RDATA;
						nxt_s.sh = s_ff.mem[s_ff.addr];
						nxt_s.drv = ~s_ff.mem[s_ff.addr][7];
						nxt_s.addr = see_next_addr(s_ff.addr, 1'b0);
					end else begin
						nxt_s.st = SEE_IDLE;
					end
				end
				default: begin
					nxt_s.st = SEE_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			s_ff <= '0;
			s_ff.scl_s <= 3'h7;
			s_ff.sda_s <= 3'h7;
			s_ff.mode_s <= 2'h3;
			s_ff.mem <= {SEE_MEM_BYTES{SEE_ERASED_BYTE}};
		end else begin
			s_ff <= nxt_s;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);

	sequence seq_write_stop;
		(s_ff.st == SEE_WDATA || s_ff.st == SEE_IDLE) && s_ff.wr_any && stop;
	endsequence

	sequence seq_sel_byte_done;
		s_ff.st == SEE_SEL && fall && s_ff.bits == SEE_BITS_BYTE;
	endsequence

	sequence seq_read_load;
		fall && (s_ff.st == SEE_ACK && s_ff.after == SEE_RDATA || s_ff.st == SEE_RACK && s_ff.mack);
	endsequence

	a_start_to_sel: assert property (start && s_ff.st != SEE_PROG |=> s_ff.st == SEE_SEL && !s_ff.drv)
		else $error("start not taken");
	a_read_stop_idle: assert property (stop && s_ff.st inside {SEE_RDATA, SEE_RACK} |=> s_ff.st == SEE_IDLE)
		else $error("read stop did not idle");
	a_ack_release: assert property (s_ff.st == SEE_ACK && fall && s_ff.after != SEE_RDATA |=> !s_ff.drv)
		else $error("ack not released");
	a_rise_sample: assert property (rise && s_ff.st == SEE_SEL && s_ff.bits < SEE_BITS_BYTE
		|=> s_ff.sh == {$past(s_ff.sh[6:0]), $past(sda)})
		else $error("bit not sampled on rise");
	a_sel_match: assert property (seq_sel_byte_done |=> s_ff.drv == ($past(s_ff.sh[7:1]) == DEV_ID))
		else $error("select ack wrong");
	a_page_wrap: assert property (push && !s_ff.mode_s[1] |=> s_ff.addr[7:3] == $past(s_ff.addr[7:3]))
		else $error("page address left row");
	a_write_prog: assert property (seq_write_stop |=> s_ff.st == SEE_PROG ##1 busy[*8])
		else $error("program cycle not started");
	a_prog_quiet: assert property (s_ff.st == SEE_PROG |-> !s_ff.drv && sda_oe_n)
		else $error("drove bus while programming");
	a_read_inc: assert property (s_ff.st == SEE_ACK && fall && s_ff.after == SEE_RDATA
		|=> s_ff.addr == 8'($past(s_ff.addr) + 8'h01) && s_ff.sh == $past(s_ff.mem[s_ff.addr]))
		else $error("read counter not advanced");
	a_nack_ends: assert property (s_ff.st == SEE_RACK && fall && !s_ff.mack && !start && !stop
		|=> s_ff.st == SEE_IDLE)
		else $error("read not ended on nack");
	a_idle_wait: assert property (s_ff.st == SEE_IDLE && !start |=> s_ff.st inside {SEE_IDLE, SEE_PROG})
		else $error("idle left without start");
	a_idle_quiet: assert property (s_ff.st == SEE_IDLE |-> !s_ff.drv)
		else $error("drove bus while idle");
	a_stop_release: assert property (stop && s_ff.st != SEE_PROG |=> !s_ff.drv)
		else $error("bus held after stop");
	a_byte_release: assert property (s_ff.st == SEE_RDATA && fall && s_ff.bits == SEE_BITS_BYTE
		|=> !s_ff.drv && s_ff.st == SEE_RACK)
		else $error("read byte not released");
	a_addr_load: assert property (s_ff.st == SEE_ADDR && fall && s_ff.bits == SEE_BITS_BYTE
		|=> s_ff.addr == $past(s_ff.sh) && s_ff.drv)
		else $error("address not loaded");
	a_multi_inc: assert property (push && s_ff.mode_s[1]
		|=> s_ff.addr == 8'($past(s_ff.addr) + 8'h01))
		else $error("multibyte address not advanced");
	a_data_ack: assert property (push |=> s_ff.drv && s_ff.st == SEE_ACK)
		else $error("data byte not acknowledged");
	a_long_prog: assert property (s_ff.st != SEE_PROG && stop && s_ff.wr_any && s_ff.span
		|=> s_ff.tmr == 32'(PROG2_CYC - 1))
		else $error("two-row program time wrong");
	a_short_prog: assert property (s_ff.st != SEE_PROG && stop && s_ff.wr_any && !s_ff.span
		|=> s_ff.tmr == 32'(PROG_CYC - 1))
		else $error("one-row program time wrong");
	a_prog_hold: assert property (s_ff.st == SEE_PROG && s_ff.tmr != '0 |=> busy)
		else $error("program cycle ended early");
	a_poll_nack: assert property (s_ff.st == SEE_PROG && start |=> s_ff.st != SEE_SEL && sda_oe_n)
		else $error("select taken while programming");
	a_read_first: assert property (s_ff.st == SEE_ACK && fall && s_ff.after == SEE_RDATA
		|=> s_ff.drv == !$past(s_ff.mem[s_ff.addr][7]))
		else $error("first read bit wrong");
	a_commit_byte: assert property (s_ff.st == SEE_PROG && pop_v
		|=> s_ff.mem[$past(pop_d.addr)] == $past(pop_d.data))
		else $error("buffered byte not committed");
	a_read_wrap: assert property (seq_read_load ##0 s_ff.addr == 8'hFF |=> s_ff.addr == 8'h00)
		else $error("read counter did not wrap");
endmodule : see_slave

`default_nettype wire

// ### verif/see_master.sv
// bus master model driving the serial clock and data line
`timescale 1ns/1ns
`default_nettype none
module see_master (
	input wire logic ref_clk,
	input wire logic sda_w,
	output logic scl,
	output logic sda_m
);
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : tick
	// data moves only while clock low, read back mid high phase
	task automatic bit_io(input logic b, output logic r);
		sda_m <= b;
		tick(4);
		scl <= 1'b1;
		tick(4);
		r = sda_w;
		tick(4);
		scl <= 1'b0;
		tick(4);
	endtask : bit_io
	task automatic start();
		sda_m <= 1'b1;
		tick(4);
		scl <= 1'b1;
		tick(4);
		sda_m <= 1'b0;
		tick(4);
		scl <= 1'b0;
		tick(4);
	endtask : start
	// clock left standing high after the frame
	task automatic stop();
		sda_m <= 1'b0;
		tick(4);
		scl <= 1'b1;
		tick(4);
		sda_m <= 1'b1;
		tick(8);
	endtask : stop
	task automatic put(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask : put
	task automatic get(input logic mack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(~mack, r);
	endtask : get
endmodule : see_master
`default_nettype wire

// ### verif/see_slave_tb.sv
// self-checking bench for the serial memory slave
`timescale 1ns/1ns
`default_nettype none
module see_slave_tb;
	import see_pkg::*;
	localparam int P1 = 400;
	localparam int P2 = 800;
	localparam logic [6:0] ID = 7'h3B; // arbitrary value
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic mode_in = 1'b1;
	logic scl, sda_m, sda_out, sda_oe_n, busy, busy_q;
	logic [7:0] mem [256];
	logic [7:0] ctr = 8'h00;
	int n_errors = 0;
	int cmp_count = 0;
	int blen = 0;
	wire sda_w = sda_m & (sda_oe_n | sda_out);
	always #2 ref_clk = ~ref_clk;
	see_slave #(.PROG_CYC(P1), .PROG2_CYC(P2), .DEV_ID(ID)) uut (.ref_clk(ref_clk), .reset(reset),
		.scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .mode_in(mode_in), .busy(busy));
	see_master m (.ref_clk(ref_clk), .sda_w(sda_w), .scl(scl), .sda_m(sda_m));
	// length of the last program cycle
	always @(posedge ref_clk) begin
		busy_q <= busy;
		if (busy && !busy_q)
			blen <= 1;
		else if (busy)
			blen <= blen + 1;
	end
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk
	task automatic sel(input logic rw, input logic exp);
		logic k;
		m.put({ID, rw}, k);
		chk("select ack", 16'(exp), 16'(k));
	endtask : sel
	task automatic wr(input logic md, input logic [7:0] a, input logic [7:0] d[$], input int tmin);
		logic k;
		logic [7:0] p;
		int n;
		mode_in <= md;
		p = a;
		m.start();
		sel(1'b0, 1'b1);
		m.put(a, k);
		chk("address ack", 1, 16'(k));
		foreach (d[i]) begin
			m.put(d[i], k);
			chk("data ack", 1, 16'(k));
			mem[p] = d[i];
			p = md ? p + 8'h01 : {p[7:3], 3'(p[2:0] + 3'h1)};
		end
		m.stop();
		repeat (3) @(posedge ref_clk);
		chk("busy", 1, 16'(busy));
		m.start();
		sel(1'b0, 1'b0);
		n = 0;
		do begin
			m.start();
			m.put({ID, 1'b0}, k);
			n++;
		end while (!k && n < 20);
		m.stop();
		chk("poll ack", 1, 16'(k));
		chk("program time", 1, 16'(blen >= tmin && blen <= tmin + 8));
	endtask : wr
	task automatic rd(input logic ld, input logic [7:0] a, input int n);
		logic k;
		logic [7:0] q;
		mode_in <= ~mode_in;
		if (ld) begin
			m.start();
			sel(1'b0, 1'b1);
			m.put(a, k);
			chk("address ack", 1, 16'(k));
			ctr = a;
		end
		m.start();
		sel(1'b1, 1'b1);
		for (int i = 0; i < n; i++) begin
			m.get(i < n - 1, q);
			chk("read data", 16'(mem[ctr]), 16'(q));
			ctr++;
		end
		m.stop();
	endtask : rd
	task automatic t_refuse();
		logic k;
		m.bit_io(1'b1, k); // clock brought low first, so no start forms
		m.put({ID, 1'b1}, k);
		chk("no start ack", 0, 16'(k));
		m.stop();
		m.start();
		m.put({ID ^ 7'h01, 1'b1}, k);
		chk("wrong id ack", 0, 16'(k));
		m.stop();
	endtask : t_refuse
	task automatic t_multi();
		wr(1'b1, 8'h10, '{8'h11, 8'h22}, P1);
		wr(1'b1, 8'h0E, '{8'hA1, 8'hA2, 8'hA3, 8'hA4}, P2);
		rd(1'b1, 8'h0E, 5);
	endtask : t_multi
	task automatic t_page();
		wr(1'b0, 8'h1E, '{8'hB1, 8'hB2, 8'hB3}, P1);
		rd(1'b1, 8'h18, 1);
		rd(1'b1, 8'h1E, 2);
		rd(1'b0, 8'h00, 1);
	endtask : t_page
	task automatic t_wrap();
		wr(1'b1, 8'hFF, '{8'hC5, 8'h5A}, P2);
		rd(1'b1, 8'hFF, 2);
	endtask : t_wrap
	task automatic t_blank();
		rd(1'b0, 8'h00, 2);
	endtask : t_blank
	// stop after an acknowledged byte; next byte has its top bit set, so stop can form
	task automatic t_stop_read();
		logic k;
		logic [7:0] q;
		m.start();
		sel(1'b0, 1'b1);
		m.put(8'h0E, k);
		chk("address ack", 1, 16'(k));
		m.start();
		sel(1'b1, 1'b1);
		m.get(1'b1, q);
		chk("read data", 16'(mem[8'h0E]), 16'(q));
		m.stop();
		ctr = 8'h10;
		rd(1'b0, 8'h00, 1);
	endtask : t_stop_read
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : close_out
	initial begin
		foreach (mem[i]) mem[i] = SEE_ERASED_BYTE;
		repeat (16) @(posedge ref_clk);
		reset <= 1'b0;
		repeat (8) @(posedge ref_clk);
		t_refuse();
		t_blank();
		t_multi();
		t_stop_read();
		t_page();
		t_wrap();
		close_out();
	end
	initial begin
		repeat (80000) @(posedge ref_clk);
		n_errors++;
		close_out();
	end
endmodule : see_slave_tb
`default_nettype wire
